// [tsq_decoder.sv]
// Trigger step sequencer: APB registers, step queue, command decode and execute
module tsq_decoder #(
    parameter int STEP_W = 5
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [tsq_pkg::TSQ_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [15:0]                    trig_in,
    output tsq_pkg::tsq_pulse_s                 pulse_out,
    output logic      [15:0]                    adc_channel_select
);
    import tsq_pkg::*;

    localparam int DW = TSQ_DATA_W;

    // Step queue memory, no reset
    logic [DW-1:0] queue_mem [TSQ_QWORDS];

    tsq_state_e     state_r, state_nxt;
    logic [STEP_W-1:0] queue_pointer_r, queue_pointer_nxt;
    logic [DW-1:0]  limit_r [TSQ_TGT_NUM];
    logic [DW-1:0]  limit_nxt [TSQ_TGT_NUM];
    logic [DW-1:0]  hold_value_r, hold_value_nxt;
    logic [DW-1:0]  adjust_value_r, adjust_value_nxt;
    logic [31:0]    bte_r, bte_nxt;
    logic [DW-1:0]  loop_counter_0_r, loop_counter_0_nxt;
    logic [DW-1:0]  loop_counter_1_r, loop_counter_1_nxt;
    logic [DW-1:0]  timer_r, timer_nxt;
    logic [DW-1:0]  adc_sel_r, adc_sel_nxt;
    logic           sequencer_enable_r, sequencer_enable_nxt;
    logic           sequencer_start_r, sequencer_start_nxt;
    logic           software_trigger_bit_r, software_trigger_bit_nxt;
    logic           swt_prev_r, swt_prev_nxt;
    logic           sd_en_r, sd_en_nxt;
    logic           wait_tmr1_r, wait_tmr1_nxt;
    logic [1:0]     wait_kind_r, wait_kind_nxt;
    logic [3:0]     wait_sel_r, wait_sel_nxt;
    logic [15:0]    trig_prev_r;
    tsq_pulse_s     pulse_r, pulse_nxt;
    logic [31:0]    prdata_r, prdata_nxt;
    logic           q_we;
    logic [3:0]     q_widx;

    localparam logic [1:0] WK_RISE = 2'd0;
    localparam logic [1:0] WK_FALL = 2'd1;
    localparam logic [1:0] WK_TMR  = 2'd2;
    localparam logic [1:0] WK_SWT  = 2'd3;
    // Limit array indices: c0lim, c1lim, t0lim, t1lim, sdlim, literal
    localparam int IX_C0 = 0;
    localparam int IX_C1 = 1;
    localparam int IX_T0 = 2;
    localparam int IX_T1 = 3;
    localparam int IX_SD = 4;
    localparam int IX_LIT = 5;

    logic        running;
    logic        apb_wr, apb_rd;
    logic [15:0] qword;
    tsq_step_s   step;
    logic [4:0]  val5;
    logic        rise_seen, fall_seen;

    assign running = sequencer_enable_r && sequencer_start_r;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign prdata  = prdata_r;
    assign pulse_out = pulse_r;
    assign adc_channel_select = adc_sel_r;

    // Fetch: odd step high byte
    assign qword = queue_mem[queue_pointer_r[STEP_W-1:1]];
    assign step  = queue_pointer_r[0] ? qword[15:8] : qword[7:0];
    assign val5  = {step.cmd[0], step.opt};
    assign rise_seen = trig_in[wait_sel_r] && !trig_prev_r[wait_sel_r];
    assign fall_seen = !trig_in[wait_sel_r] && trig_prev_r[wait_sel_r];

    assign q_we   = apb_wr && !running && paddr >= TSQ_OFF_QUE && paddr <= TSQ_OFF_QEND;
    assign q_widx = paddr[5:2];

    always_ff @(posedge pclk) begin
        if (q_we) begin
            queue_mem[q_widx] <= pwdata[15:0];
        end
    end

    always_comb begin
        state_nxt = state_r;
        queue_pointer_nxt = queue_pointer_r;
        limit_nxt = limit_r;
        hold_value_nxt = hold_value_r;
        adjust_value_nxt = adjust_value_r;
        bte_nxt = bte_r;
        loop_counter_0_nxt = loop_counter_0_r;
        loop_counter_1_nxt = loop_counter_1_r;
        timer_nxt = timer_r;
        adc_sel_nxt = adc_sel_r;
        sequencer_enable_nxt = sequencer_enable_r;
        sequencer_start_nxt = sequencer_start_r;
        software_trigger_bit_nxt = software_trigger_bit_r;
        swt_prev_nxt = software_trigger_bit_r;
        sd_en_nxt = sd_en_r;
        wait_tmr1_nxt = wait_tmr1_r;
        wait_kind_nxt = wait_kind_r;
        wait_sel_nxt = wait_sel_r;
        pulse_nxt = '0;
        prdata_nxt = prdata_r;

        // APB writes; configuration other than CTRL and BTE locked while running
        if (apb_wr) begin
            case (paddr)
                TSQ_OFF_CTRL: begin
                    sequencer_enable_nxt = pwdata[TSQ_CTRL_EN];
                    sequencer_start_nxt = pwdata[TSQ_CTRL_STRT];
                    software_trigger_bit_nxt = pwdata[TSQ_CTRL_SWT];
                    sd_en_nxt = pwdata[TSQ_CTRL_SDEN];
                end
                TSQ_OFF_BTE: bte_nxt = pwdata;
                default: begin
                    if (!running) begin
                        case (paddr)
                            TSQ_OFF_HOLD:  hold_value_nxt = pwdata[DW-1:0];
                            TSQ_OFF_ADJ:   adjust_value_nxt = pwdata[DW-1:0];
                            TSQ_OFF_LIT:   limit_nxt[IX_LIT] = pwdata[DW-1:0];
                            TSQ_OFF_C0LIM: limit_nxt[IX_C0] = pwdata[DW-1:0];
                            TSQ_OFF_C1LIM: limit_nxt[IX_C1] = pwdata[DW-1:0];
                            TSQ_OFF_T0LIM: limit_nxt[IX_T0] = pwdata[DW-1:0];
                            TSQ_OFF_T1LIM: limit_nxt[IX_T1] = pwdata[DW-1:0];
                            TSQ_OFF_SDLIM: limit_nxt[IX_SD] = pwdata[DW-1:0];
                            TSQ_OFF_QPTR:  queue_pointer_nxt = pwdata[STEP_W-1:0];
                            TSQ_OFF_ADCSEL: adc_sel_nxt = pwdata[DW-1:0];
                            default: ;
                        endcase
                    end
                end
            endcase
        end

        // APB read data captured in setup phase
        if (apb_rd) begin
            case (paddr)
                TSQ_OFF_CTRL:  prdata_nxt = {28'h0, sd_en_r, software_trigger_bit_r,
                                             sequencer_start_r, sequencer_enable_r};
                TSQ_OFF_STAT:  prdata_nxt = {29'h0, state_r};
                TSQ_OFF_BTE:   prdata_nxt = bte_r;
                TSQ_OFF_HOLD:  prdata_nxt = {16'h0, hold_value_r};
                TSQ_OFF_ADJ:   prdata_nxt = {16'h0, adjust_value_r};
                TSQ_OFF_LIT:   prdata_nxt = {16'h0, limit_r[IX_LIT]};
                TSQ_OFF_C0LIM: prdata_nxt = {16'h0, limit_r[IX_C0]};
                TSQ_OFF_C1LIM: prdata_nxt = {16'h0, limit_r[IX_C1]};
                TSQ_OFF_T0LIM: prdata_nxt = {16'h0, limit_r[IX_T0]};
                TSQ_OFF_T1LIM: prdata_nxt = {16'h0, limit_r[IX_T1]};
                TSQ_OFF_SDLIM: prdata_nxt = {16'h0, limit_r[IX_SD]};
                TSQ_OFF_QPTR:  prdata_nxt = {27'h0, queue_pointer_r};
                TSQ_OFF_ADCSEL: prdata_nxt = {16'h0, adc_sel_r};
                TSQ_OFF_CNT:   prdata_nxt = {loop_counter_1_r, loop_counter_0_r};
                default: begin
                    if (paddr >= TSQ_OFF_QUE && paddr <= TSQ_OFF_QEND) begin
                        prdata_nxt = {16'h0, queue_mem[paddr[5:2]]};
                    end else begin
                        prdata_nxt = 32'h0;
                    end
                end
            endcase
        end

        // Sequencer
        case (running ? state_r : TSQ_ST_IDLE)
            TSQ_ST_IDLE: begin
                if (running) begin
                    state_nxt = TSQ_ST_EXEC;
                end
            end
            TSQ_ST_EXEC: begin
                queue_pointer_nxt = queue_pointer_r + 1'b1;
                state_nxt = sd_en_r ? TSQ_ST_DELAY : TSQ_ST_EXEC;
                timer_nxt = '0;
                case (step.cmd)
                    TSQ_CMD_CTRL: begin
                        case (step.opt)
                            TSQ_OPT_SDOFF: begin
                                sd_en_nxt = 1'b0;
                                state_nxt = TSQ_ST_EXEC;
                            end
                            TSQ_OPT_SDON: sd_en_nxt = 1'b1;
                            TSQ_OPT_TMR0, TSQ_OPT_TMR1: begin
                                wait_kind_nxt = WK_TMR;
                                wait_tmr1_nxt = step.opt[0];
                                state_nxt = TSQ_ST_WAIT;
                            end
                            TSQ_OPT_SWT: begin
                                wait_kind_nxt = WK_SWT;
                                state_nxt = TSQ_ST_WAIT;
                            end
                            TSQ_OPT_C0ADC:  adc_sel_nxt = loop_counter_0_r;
                            TSQ_OPT_C1ADC:  adc_sel_nxt = loop_counter_1_r;
                            TSQ_OPT_LITADC: adc_sel_nxt = limit_r[IX_LIT];
                            TSQ_OPT_BCAST:  pulse_nxt.trig = bte_r;
                            default: ;
                        endcase
                    end
                    TSQ_CMD_ADDCP: begin
                        if (step.opt[2:0] < 3'(TSQ_TGT_NUM)) begin
                            if (!step.opt[3]) begin
                                limit_nxt[step.opt[2:0]] = limit_r[step.opt[2:0]]
                                                           + adjust_value_r;
                            end else begin
                                limit_nxt[step.opt[2:0]] = hold_value_r;
                            end
                        end
                    end
                    TSQ_CMD_WRISE, TSQ_CMD_WFALL: begin
                        wait_kind_nxt = step.cmd[0] ? WK_FALL : WK_RISE;
                        wait_sel_nxt = step.opt;
                        state_nxt = TSQ_ST_WAIT;
                    end
                    TSQ_CMD_IRQ: begin
                        if (step.opt < 4'(TSQ_IRQ_NUM)) begin
                            pulse_nxt.irq[step.opt[1:0]] = 1'b1;
                        end
                    end
                    default: begin
                        case (step.cmd[3:1])
                            TSQ_CMD_STRB: adc_sel_nxt[4:0] = val5 & TSQ_CHSEL_MSK;
                            TSQ_CMD_TRIG: pulse_nxt.trig[val5] = 1'b1;
                            TSQ_CMD_JMP:  queue_pointer_nxt = val5;
                            TSQ_CMD_LOOP0: begin
                                if (loop_counter_0_r != limit_r[IX_C0]) begin
                                    loop_counter_0_nxt = loop_counter_0_r + 1'b1;
                                    queue_pointer_nxt = val5;
                                end
                            end
                            TSQ_CMD_LOOP1: begin
                                if (loop_counter_1_r != limit_r[IX_C1]) begin
                                    loop_counter_1_nxt = loop_counter_1_r + 1'b1;
                                    queue_pointer_nxt = val5;
                                end
                            end
                            default: ;
                        endcase
                    end
                endcase
                if (state_nxt == TSQ_ST_WAIT) begin
                    queue_pointer_nxt = queue_pointer_r;
                end
            end
            TSQ_ST_WAIT: begin
                case (wait_kind_r)
                    WK_RISE: if (rise_seen) state_nxt = sd_en_r ? TSQ_ST_DELAY : TSQ_ST_EXEC;
                    WK_FALL: if (fall_seen) state_nxt = sd_en_r ? TSQ_ST_DELAY : TSQ_ST_EXEC;
                    WK_TMR: begin
                        if (timer_r == limit_r[wait_tmr1_r ? IX_T1 : IX_T0]) begin
                            state_nxt = sd_en_r ? TSQ_ST_DELAY : TSQ_ST_EXEC;
                            timer_nxt = '0;
                        end else begin
                            timer_nxt = timer_r + 1'b1;
                        end
                    end
                    default: begin
                        if (software_trigger_bit_r && !swt_prev_r) begin
                            state_nxt = sd_en_r ? TSQ_ST_DELAY : TSQ_ST_EXEC;
                        end
                    end
                endcase
                if (state_nxt != TSQ_ST_WAIT) begin
                    queue_pointer_nxt = queue_pointer_r + 1'b1;
                end
            end
            TSQ_ST_DELAY: begin
                if (timer_r >= limit_r[IX_SD]) begin
                    state_nxt = TSQ_ST_EXEC;
                    timer_nxt = '0;
                end else begin
                    timer_nxt = timer_r + 1'b1;
                end
            end
            default: state_nxt = TSQ_ST_IDLE;
        endcase
        if (!running) begin
            state_nxt = TSQ_ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= TSQ_ST_IDLE;
            queue_pointer_r <= '0;
            for (int i = 0; i < TSQ_TGT_NUM; i++) begin
                limit_r[i] <= '0;
            end
            hold_value_r <= '0;
            adjust_value_r <= '0;
            bte_r <= '0;
            loop_counter_0_r <= '0;
            loop_counter_1_r <= '0;
            timer_r <= '0;
            adc_sel_r <= '0;
            sequencer_enable_r <= 1'b0;
            sequencer_start_r <= 1'b0;
            software_trigger_bit_r <= 1'b0;
            swt_prev_r <= 1'b0;
            sd_en_r <= 1'b0;
            wait_tmr1_r <= 1'b0;
            wait_kind_r <= WK_RISE;
            wait_sel_r <= '0;
            trig_prev_r <= '0;
            pulse_r <= '0;
            prdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            queue_pointer_r <= queue_pointer_nxt;
            limit_r <= limit_nxt;
            hold_value_r <= hold_value_nxt;
            adjust_value_r <= adjust_value_nxt;
            bte_r <= bte_nxt;
            loop_counter_0_r <= loop_counter_0_nxt;
            loop_counter_1_r <= loop_counter_1_nxt;
            timer_r <= timer_nxt;
            adc_sel_r <= adc_sel_nxt;
            sequencer_enable_r <= sequencer_enable_nxt;
            sequencer_start_r <= sequencer_start_nxt;
            software_trigger_bit_r <= software_trigger_bit_nxt;
            swt_prev_r <= swt_prev_nxt;
            sd_en_r <= sd_en_nxt;
            wait_tmr1_r <= wait_tmr1_nxt;
            wait_kind_r <= wait_kind_nxt;
            wait_sel_r <= wait_sel_nxt;
            trig_prev_r <= trig_in;
            pulse_r <= pulse_nxt;
            prdata_r <= prdata_nxt;
        end
    end

    AST_JUMP_LOADS: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3:1] == TSQ_CMD_JMP
        |=> queue_pointer_r == $past(val5))
        else $error("Jump did not load pointer");
    AST_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3] == 1'b0 && state_nxt != TSQ_ST_WAIT
        |=> queue_pointer_r == $past(queue_pointer_r) + 1'b1)
        else $error("Pointer did not advance");
    AST_TRIG_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3:1] == TSQ_CMD_TRIG
        |=> $onehot(pulse_out.trig) && pulse_out.trig[$past(val5)])
        else $error("Trigger pulse wrong");
    AST_PULSE_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        pulse_out.trig != '0 |=> pulse_out.trig == '0 || $past(state_r) == TSQ_ST_EXEC)
        else $error("Trigger held too long");
    AST_STRB: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3:1] == TSQ_CMD_STRB
        |=> adc_channel_select[4:0] == $past(val5))
        else $error("Channel field not written");
    AST_LOOP0_EQ: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3:1] == TSQ_CMD_LOOP0
        && loop_counter_0_r == limit_r[IX_C0]
        |=> queue_pointer_r == $past(queue_pointer_r) + 1'b1 && $stable(loop_counter_0_r))
        else $error("Loop 0 exit wrong");
    AST_LOOP1_NE: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == TSQ_ST_EXEC && running && step.cmd[3:1] == TSQ_CMD_LOOP1
        && loop_counter_1_r != limit_r[IX_C1]
        |=> loop_counter_1_r == $past(loop_counter_1_r) + 1'b1)
        else $error("Loop 1 count wrong");
    AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        running && $past(running) |-> $stable(hold_value_r) && $stable(adjust_value_r))
        else $error("Locked register changed");
endmodule : tsq_decoder

// [tsq_pkg.sv]
// Package for the trigger step command decoder: register map, codes, carriers
package tsq_pkg;
    localparam int          TSQ_ADDR_W     = 8;
    localparam int          TSQ_DATA_W     = 16;
    localparam int          TSQ_STEPS      = 32;
    localparam int          TSQ_QWORDS     = 16;
    // Register byte offsets
    localparam logic [7:0]  TSQ_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  TSQ_OFF_STAT   = 8'h04;
    localparam logic [7:0]  TSQ_OFF_BTE    = 8'h08;
    localparam logic [7:0]  TSQ_OFF_HOLD   = 8'h0c;
    localparam logic [7:0]  TSQ_OFF_ADJ    = 8'h10;
    localparam logic [7:0]  TSQ_OFF_LIT    = 8'h14;
    localparam logic [7:0]  TSQ_OFF_C0LIM  = 8'h18;
    localparam logic [7:0]  TSQ_OFF_C1LIM  = 8'h1c;
    localparam logic [7:0]  TSQ_OFF_T0LIM  = 8'h20;
    localparam logic [7:0]  TSQ_OFF_T1LIM  = 8'h24;
    localparam logic [7:0]  TSQ_OFF_SDLIM  = 8'h28;
    localparam logic [7:0]  TSQ_OFF_QPTR   = 8'h2c;
    localparam logic [7:0]  TSQ_OFF_ADCSEL = 8'h30;
    localparam logic [7:0]  TSQ_OFF_CNT    = 8'h34;
    localparam logic [7:0]  TSQ_OFF_QUE    = 8'h40;
    localparam logic [7:0]  TSQ_OFF_QEND   = 8'h7c;
    // Control register bits
    localparam int          TSQ_CTRL_EN    = 0;
    localparam int          TSQ_CTRL_STRT  = 1;
    localparam int          TSQ_CTRL_SWT   = 2;
    localparam int          TSQ_CTRL_SDEN  = 3;
    // Command codes (step bits 7:4; the 3-bit codes are step bits 7:5)
    localparam logic [3:0]  TSQ_CMD_CTRL   = 4'h0;
    localparam logic [3:0]  TSQ_CMD_ADDCP  = 4'h1;
    localparam logic [2:0]  TSQ_CMD_STRB   = 3'h1;
    localparam logic [3:0]  TSQ_CMD_WRISE  = 4'h4;
    localparam logic [3:0]  TSQ_CMD_WFALL  = 4'h5;
    localparam logic [3:0]  TSQ_CMD_IRQ    = 4'h7;
    localparam logic [2:0]  TSQ_CMD_TRIG   = 3'h4;
    localparam logic [2:0]  TSQ_CMD_JMP    = 3'h5;
    localparam logic [2:0]  TSQ_CMD_LOOP0  = 3'h6;
    localparam logic [2:0]  TSQ_CMD_LOOP1  = 3'h7;
    // Control options
    localparam logic [3:0]  TSQ_OPT_SDOFF  = 4'h2;
    localparam logic [3:0]  TSQ_OPT_SDON   = 4'h6;
    localparam logic [3:0]  TSQ_OPT_TMR0   = 4'h8;
    localparam logic [3:0]  TSQ_OPT_TMR1   = 4'h9;
    localparam logic [3:0]  TSQ_OPT_SWT    = 4'hb;
    localparam logic [3:0]  TSQ_OPT_C0ADC  = 4'hc;
    localparam logic [3:0]  TSQ_OPT_C1ADC  = 4'hd;
    localparam logic [3:0]  TSQ_OPT_LITADC = 4'he;
    localparam logic [3:0]  TSQ_OPT_BCAST  = 4'hf;
    localparam int          TSQ_TGT_NUM    = 6;
    localparam int          TSQ_IRQ_NUM    = 4;
    localparam logic [4:0]  TSQ_CHSEL_MSK  = 5'h1f;

    typedef enum logic [2:0] {
        TSQ_ST_IDLE  = 3'b000,
        TSQ_ST_EXEC  = 3'b001,
        TSQ_ST_WAIT  = 3'b010,
        TSQ_ST_DELAY = 3'b011
    } tsq_state_e;

    typedef struct packed {
        logic [3:0] cmd;
        logic [3:0] opt;
    } tsq_step_s;

    typedef struct packed {
        logic [31:0] trig;
        logic [3:0]  irq;
    } tsq_pulse_s;
endpackage : tsq_pkg

// [tsq_periph_model.sv]
// Far-side peripheral event sources for the trigger step bench
module tsq_periph_model (
    input  wire logic        pclk,
    input  wire logic        go,
    output logic      [15:0] trig_in
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    initial trig_in = 16'h0000;
    // Unselected inputs toggle every cycle
    always @(posedge pclk) begin
        cnt <= go ? cnt + 1 : 0;
        trig_in[15:2] <= ~trig_in[15:2];
        trig_in[0] <= ~trig_in[0];
        trig_in[1] <= go && cnt >= 5 && cnt < 15;
    end
endmodule : tsq_periph_model

// [trigger_step_command_decoder_tb.sv]
// Self-checking bench for the trigger step command decoder
module trigger_step_command_decoder_tb import tsq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr;
    logic [15:0] trig_in, adc_channel_select, adc_prev = 16'h0, lit, hold, bte;
    tsq_pulse_s  pulse_out;
    logic [35:0] got_p[$], exp_p[$];
    logic [15:0] got_a[$], exp_a[$];
    time         got_t[$];
    logic [7:0]  prog[18];
    int n_fail = 0, checks = 0, seed = 32'h1957, lim, sd;

    tsq_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trig_in(trig_in), .pulse_out(pulse_out), .adc_channel_select(adc_channel_select));
    tsq_periph_model u_far (.pclk(pclk), .go(go), .trig_in(trig_in));

    initial forever #20 pclk = ~pclk;
    // Log every pulse and every channel-select change
    always @(posedge pclk) begin
        if (presetn && pulse_out !== '0) begin
            got_p.push_back(pulse_out);
            got_t.push_back($time);
        end
        if (presetn && adc_channel_select !== adc_prev) got_a.push_back(adc_channel_select);
        adc_prev <= adc_channel_select;
    end

    task chk(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task give_verdict;
        $display("counts: checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (3000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end

    initial begin
        hold = 16'($random(seed)) & 16'h0003;
        lit = 16'($random(seed)) | 16'h8000;
        bte = 16'($random(seed)) | 16'h0001;
        lim = int'(hold) + 1;
        prog = '{8'h18, 8'h10, 8'h25, 8'h31, 8'h83, 8'h9f, 8'h72, 8'h60, 8'hc4,
                 8'h41, 8'h51, 8'h0b, 8'h0c, 8'h0f, 8'h08, 8'hb0, 8'h0e, 8'hb1};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1, TSQ_OFF_HOLD, 32'(hold));
        apb(1, TSQ_OFF_ADJ, 32'h1);
        apb(1, TSQ_OFF_LIT, 32'(lit));
        apb(1, TSQ_OFF_BTE, 32'(bte));
        apb(1, TSQ_OFF_T0LIM, 32'h4);
        for (int n = 0; n < 9; n++) apb(1, TSQ_OFF_QUE + 8'(4 * n), {16'h0, prog[2*n+1], prog[2*n]});
        apb(0, TSQ_OFF_QUE + 8'h04, 32'h0);
        chk(36'(rd), 36'h3125);
        apb(0, 8'h38, 32'h0);
        chk(36'(rd), 36'h0);
        chk(36'(pslverr), 36'h0);
        $display("done: setup");
        apb(1, TSQ_OFF_CTRL, 32'h3);
        repeat (40) @(posedge pclk);
        apb(0, TSQ_OFF_QPTR, 32'h0);
        chk(36'(rd), 36'd9);
        apb(1, TSQ_OFF_HOLD, 32'h5a5a);
        apb(0, TSQ_OFF_HOLD, 32'h0);
        chk(36'(rd), 36'(hold));
        go <= 1'b1;
        repeat (40) @(posedge pclk);
        apb(0, TSQ_OFF_QPTR, 32'h0);
        chk(36'(rd), 36'd11);
        apb(1, TSQ_OFF_CTRL, 32'h7);
        repeat (40) @(posedge pclk);
        apb(0, TSQ_OFF_QPTR, 32'h0);
        chk(36'(rd), 36'd17);
        apb(0, TSQ_OFF_CNT, 32'h0);
        chk(36'(rd), 36'(lim));
        apb(0, TSQ_OFF_C0LIM, 32'h0);
        chk(36'(rd), 36'(lim));
        apb(1, TSQ_OFF_CTRL, 32'h0);
        $display("done: run");
        for (int i = 0; i <= lim; i++) exp_p = {exp_p, 36'h80, 36'h800000000, 36'h4};
        exp_p.push_back({16'h0, bte, 4'h0});
        exp_a = '{16'h0005, 16'h0011, 16'(lim), lit};
        chk(36'(got_p.size()), 36'(exp_p.size()));
        foreach (exp_p[i]) chk(got_p[i], exp_p[i]);
        foreach (exp_a[i]) chk(36'(got_a[i]), 36'(exp_a[i]));
        $display("done: compare");
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, TSQ_OFF_QUE + 8'h04, 32'h0);
        chk(36'(rd), 36'h3125);
        apb(0, TSQ_OFF_QPTR, 32'h0);
        chk(36'(rd), 36'h0);
        $display("done: reset");
        got_p.delete();
        got_t.delete();
        got_a.delete();
        sd = $random(seed) & 3;
        apb(1, TSQ_OFF_C1LIM, 32'h2);
        apb(1, TSQ_OFF_SDLIM, 32'(sd));
        // Delay on, irq 0 looped by counter 1, channel copy, delay off, irq 1
        apb(1, TSQ_OFF_QUE, 32'h7006);
        apb(1, TSQ_OFF_QUE + 8'h04, 32'h0de1);
        apb(1, TSQ_OFF_QUE + 8'h08, 32'h7102);
        apb(1, TSQ_OFF_QUE + 8'h0c, 32'ha774);
        apb(1, TSQ_OFF_CTRL, 32'h3);
        repeat (80) @(posedge pclk);
        apb(0, TSQ_OFF_CNT, 32'h0);
        chk(36'(rd), 36'h20000);
        apb(1, TSQ_OFF_CTRL, 32'h0);
        exp_p = '{36'h1, 36'h1, 36'h1, 36'h2};
        exp_a = '{16'h0002};
        chk(36'(got_p.size()), 36'(exp_p.size()));
        foreach (exp_p[i]) chk(got_p[i], exp_p[i]);
        chk(36'(got_t[1] - got_t[0]), 36'(80 * (sd + 2)));
        chk(36'(got_t[3] - got_t[2]), 36'(40 * (3 * sd + 7)));
        chk(36'(got_a.size()), 36'(exp_a.size()));
        foreach (exp_a[i]) chk(36'(got_a[i]), 36'(exp_a[i]));
        $display("done: delay");
        give_verdict();
    end
endmodule : trigger_step_command_decoder_tb
